// file: bfpsc_asserts.sv
`timescale 1ns/1ps
module bfpsc_asserts #(
    parameter int unsigned FILTER_CYC = 8
) (
    // Clock and reset
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    // Comparator pins
    input wire bfpsc_pkg::bfpsc_pins_t pins_i,
    // Outputs watched
    input wire logic                   ch1_high_gate_o,
    input wire logic                   ch1_low_gate_o,
    input wire logic                   ch2_high_gate_o,
    input wire logic                   ch2_high_gate_oe_o,
    input wire logic                   ch2_low_gate_o,
    input wire logic                   ch2_low_gate_oe_o,
    input wire logic                   ch3_pwm_mid_o,
    input wire logic                   ch4_pwm_mid_o,
    input wire logic                   thermal_alert_out_o,
    input wire logic                   overcurrent_trip_o,
    input wire logic                   overvoltage_trip_o,
    input wire logic                   single_phase_o
);
    // ------------------------------------------------------------
    // Raw pin history
    // ------------------------------------------------------------
    logic [15:0] oc_run_q;
    logic [15:0] ov_run_q;
    logic [3:0]  clr_hist_q;
    always_ff @(posedge clk_i) begin
        oc_run_q   <= (pins_i.droop_over_multi || pins_i.droop_over_single) ? oc_run_q + 16'h1 : 16'h0;
        ov_run_q   <= pins_i.feedback_over_ref ? ov_run_q + 16'h1 : 16'h0;
        clr_hist_q <= {clr_hist_q[2:0], pins_i.thermal_above_clear};
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_single;
        single_phase_o && !overcurrent_trip_o && !overvoltage_trip_o;
    endsequence
    sequence s_inter;
        !single_phase_o && !overcurrent_trip_o && !overvoltage_trip_o;
    endsequence
    property p_oc_off;
        overcurrent_trip_o |=> !ch1_high_gate_o && !ch1_low_gate_o && !ch2_high_gate_o && !ch2_low_gate_o
            && ch3_pwm_mid_o && ch4_pwm_mid_o;
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("switch on during overcurrent trip");
    property p_ov_safe;
        overvoltage_trip_o && !overcurrent_trip_o |=> ch1_low_gate_o && !ch1_high_gate_o && ch2_low_gate_o
            && ch2_low_gate_oe_o && !ch2_high_gate_o;
    endproperty
    a_ov_safe: assert property (p_ov_safe) else $error("wrong gates during overvoltage trip");
    property p_oc_hold; overcurrent_trip_o |=> overcurrent_trip_o; endproperty
    a_oc_hold: assert property (p_oc_hold) else $error("overcurrent trip released");
    property p_ov_hold; overvoltage_trip_o |=> overvoltage_trip_o; endproperty
    a_ov_hold: assert property (p_ov_hold) else $error("overvoltage trip released");
    property p_oc_filt; $rose(overcurrent_trip_o) |-> oc_run_q >= FILTER_CYC + 2; endproperty
    a_oc_filt: assert property (p_oc_filt) else $error("overcurrent trip too early");
    property p_ov_filt; $rose(overvoltage_trip_o) |-> ov_run_q >= FILTER_CYC + 2; endproperty
    a_ov_filt: assert property (p_ov_filt) else $error("overvoltage trip too early");
    property p_th_set; pins_i.thermal_below_set [*5] |-> thermal_alert_out_o; endproperty
    a_th_set: assert property (p_th_set) else $error("thermal alert not raised");
    property p_th_clr; $fell(thermal_alert_out_o) |-> |clr_hist_q; endproperty
    a_th_clr: assert property (p_th_clr) else $error("thermal alert dropped without clear");
    property p_park;
        s_single [*2] |-> !ch2_high_gate_oe_o && !ch2_low_gate_oe_o && ch3_pwm_mid_o && ch4_pwm_mid_o;
    endproperty
    a_park: assert property (p_park) else $error("idle channels not parked");
    property p_inter;
        s_inter [*3] |-> ch2_high_gate_oe_o && ch2_low_gate_oe_o && !ch3_pwm_mid_o && !ch4_pwm_mid_o;
    endproperty
    a_inter: assert property (p_inter) else $error("channel idle in interleave");
endmodule

bind bfpsc_top bfpsc_asserts #(.FILTER_CYC(FILTER_CYC)) u_chk (
    .clk_i, .rst_i, .pins_i, .ch1_high_gate_o, .ch1_low_gate_o, .ch2_high_gate_o, .ch2_high_gate_oe_o,
    .ch2_low_gate_o, .ch2_low_gate_oe_o, .ch3_pwm_mid_o, .ch4_pwm_mid_o, .thermal_alert_out_o,
    .overcurrent_trip_o, .overvoltage_trip_o, .single_phase_o
);

// file: bfpsc_drivers.sv
`timescale 1ns/1ps
module bfpsc_drivers (
    // Pins from the controller
    input  wire logic       ch2_high_oe_i,
    input  wire logic       ch2_low_oe_i,
    input  wire logic [1:0] pwm_i,
    input  wire logic [1:0] mid_i,
    // Power stage view
    output logic            ch2_parked_o,
    output logic [1:0]      shut_o,
    output logic [1:0]      high_on_o
);
    // Undriven channel 2 gates are pulled off by the stage.
    assign ch2_parked_o = !ch2_high_oe_i && !ch2_low_oe_i;
    // A mid-level input shuts the external driver down.
    assign shut_o    = mid_i;
    assign high_on_o = pwm_i & ~mid_i;
endmodule

// file: bfpsc_pkg.sv
package bfpsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned FILTER_TIME_NS  = 20000;
    localparam int unsigned BLANK_TIME_NS   = 100000;
    // Least times round up to whole cycles.
    localparam int unsigned FILTER_CYCLES   = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLANK_CYCLES    = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CNT_W           = 16;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADR_STATUS      = 8'h00;
    localparam logic [7:0]  ADR_MASK        = 8'h04;
    localparam logic [7:0]  ADR_CTRL        = 8'h08;
    localparam logic [7:0]  ADR_STATE       = 8'h0c;
    localparam logic [7:0]  ADR_CODE        = 8'h10;

    localparam int unsigned EVT_W           = 6;
    localparam logic [5:0]  MASK_RST        = 6'h00;
    localparam int unsigned CTRL_W          = 2;
    localparam logic [1:0]  CTRL_RST        = 2'h1;
    localparam int unsigned CODE_W          = 8;
    localparam int unsigned NUM_CH          = 4;

    // Sticky event bits, same layout in status and mask.
    typedef struct packed {
        logic code_change;
        logic mode_change;
        logic thermal_clear;
        logic thermal_set;
        logic overvoltage_trip;
        logic overcurrent_trip;
    } bfpsc_evt_t;

    // Software control bits.
    typedef struct packed {
        logic force_interleave;
        logic low_power_enable;
    } bfpsc_ctrl_t;

    // Comparator and request pins from the analog side.
    typedef struct packed {
        logic droop_over_multi;
        logic droop_over_single;
        logic feedback_over_ref;
        logic thermal_below_set;
        logic thermal_above_clear;
        logic low_power_state_request;
        logic slew_busy;
    } bfpsc_pins_t;

    typedef enum logic [1:0] {
        MODE_INTERLEAVE = 2'b00,
        MODE_SINGLE     = 2'b01,
        MODE_TRANSITION = 2'b10,
        MODE_BLANK      = 2'b11
    } bfpsc_mode_t;

endpackage

// file: bfpsc_tb_top.sv
`timescale 1ns/1ps
module bfpsc_tb_top;
    localparam int F = 8;
    localparam int B = 20;
    logic                   clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, ch2_parked;
    logic [7:0]             wb_adr_i, voltage_code_i;
    logic [3:0]             wb_sel_i, pwm_i;
    logic [3:0]             sel_v = 4'hf;
    logic [31:0]            wb_dat_i, wb_dat_o;
    logic                   ch1_high_gate_o, ch1_low_gate_o, ch2_high_gate_o, ch2_high_gate_oe_o, ch2_low_gate_o;
    logic                   ch2_low_gate_oe_o, ch3_pwm_out_o, ch3_pwm_mid_o, ch4_pwm_out_o, ch4_pwm_mid_o;
    logic                   thermal_alert_out_o, overcurrent_trip_o, overvoltage_trip_o, single_phase_o;
    logic [1:0]             shut, high_on;
    bfpsc_pkg::bfpsc_pins_t pins_i;
    int                     bad_count, comparisons, cycles;
    wire [5:0]              gates = {ch1_high_gate_o, ch1_low_gate_o, ch2_high_gate_o, ch2_low_gate_o,
                                     ch3_pwm_mid_o, ch4_pwm_mid_o};
    wire [5:0]              stage = {single_phase_o, ch2_parked, shut, high_on};
    wire [1:0]              trips = {overcurrent_trip_o, overvoltage_trip_o};

    bfpsc_top #(.BLANK_CYC(B), .FILTER_CYC(F)) DUT (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .irq_o, .pins_i, .voltage_code_i, .pwm_i, .ch1_high_gate_o, .ch1_low_gate_o, .ch2_high_gate_o,
        .ch2_high_gate_oe_o, .ch2_low_gate_o, .ch2_low_gate_oe_o, .ch3_pwm_out_o, .ch3_pwm_mid_o,
        .ch4_pwm_out_o, .ch4_pwm_mid_o, .thermal_alert_out_o, .overcurrent_trip_o, .overvoltage_trip_o,
        .single_phase_o
    );
    bfpsc_drivers u_drv (
        .ch2_high_oe_i(ch2_high_gate_oe_o), .ch2_low_oe_i(ch2_low_gate_oe_o),
        .pwm_i({ch4_pwm_out_o, ch3_pwm_out_o}), .mid_i({ch4_pwm_mid_o, ch3_pwm_mid_o}),
        .ch2_parked_o(ch2_parked), .shut_o(shut), .high_on_o(high_on)
    );

    task automatic final_report;
        $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel_v;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'h1 && n < 16) begin
            n++;
            @(posedge clk_i);
        end
        chk(wb_ack_o, 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i  <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'h0, adr, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, adr, d, q);
    endtask
    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'h1;
        step(3);
        rst_i <= 1'h0;
    endtask
    task automatic fault(input logic ov, input logic v);
        pins_i.feedback_over_ref <= ov & v;
        pins_i.droop_over_multi  <= !ov & v;
    endtask

    task automatic sc_regs;
        rd(bfpsc_pkg::ADR_CTRL, 32'h1);
        rd(bfpsc_pkg::ADR_MASK, 32'h0);
        sel_v = 4'h0;
        wr(bfpsc_pkg::ADR_MASK, 32'h3f);
        sel_v = 4'hf;
        rd(bfpsc_pkg::ADR_MASK, 32'h0);
        wr(bfpsc_pkg::ADR_MASK, 32'h3f);
        rd(bfpsc_pkg::ADR_MASK, 32'h3f);
        rd(8'h20, 32'h0);
    endtask
    task automatic sc_therm;
        @(posedge clk_i);
        pins_i.thermal_below_set <= 1'h1;
        step(5);
        chk(thermal_alert_out_o, 1'h1);
        pins_i.thermal_below_set <= 1'h0;
        step(8);
        chk(thermal_alert_out_o, 1'h1);
        pins_i.thermal_above_clear <= 1'h1;
        step(5);
        chk(thermal_alert_out_o, 1'h0);
        pins_i.thermal_above_clear <= 1'h0;
        rd(bfpsc_pkg::ADR_STATUS, 32'hc);
    endtask
    task automatic sc_trip(input logic ov);
        wr(bfpsc_pkg::ADR_MASK, ov ? 32'h2 : 32'h1);
        @(posedge clk_i);
        pwm_i <= 4'hf;
        pins_i.droop_over_single <= !ov;
        step(3 * F);
        chk(trips, 2'h0);
        pins_i.droop_over_single <= 1'h0;
        fault(ov, 1'h1);
        step(F - 2);
        fault(ov, 1'h0);
        step(2 * F);
        chk(trips, 2'h0);
        fault(ov, 1'h1);
        step(F + 1);
        chk(trips, 2'h0);
        step(5);
        chk(trips, ov ? 2'h1 : 2'h2);
        chk(gates, ov ? 6'h14 : 6'h03);
        chk(irq_o, 1'h1);
        fault(ov, 1'h0);
        step(10);
        chk(trips, ov ? 2'h1 : 2'h2);
        rd(bfpsc_pkg::ADR_STATUS, ov ? 32'h2 : 32'h1);
        rd(bfpsc_pkg::ADR_STATUS, 32'h0);
        chk(irq_o, 1'h0);
        do_reset;
        chk(trips, 2'h0);
    endtask
    task automatic sc_mode;
        step(6);
        chk(stage, 6'h03);
        pins_i.low_power_state_request <= 1'h0;
        step(8);
        chk(stage, 6'h3c);
        pwm_i <= 4'h0;
        step(3);
        chk({ch1_high_gate_o, ch1_low_gate_o}, 2'h1);
        pwm_i <= 4'h1;
        step(3);
        chk({ch1_high_gate_o, ch1_low_gate_o}, 2'h2);
        pins_i.droop_over_single <= 1'h1;
        step(F + 6);
        chk(overcurrent_trip_o, 1'h1);
        wr(bfpsc_pkg::ADR_CTRL, 32'h3);
        step(2);
        chk(single_phase_o, 1'h0);
        pins_i.droop_over_single <= 1'h0;
        pins_i.low_power_state_request <= 1'h1;
        do_reset;
    endtask
    task automatic sc_code;
        @(posedge clk_i);
        pins_i.low_power_state_request <= 1'h0;
        step(8);
        chk(single_phase_o, 1'h1);
        voltage_code_i <= 8'h12;
        pins_i.slew_busy <= 1'h1;
        step(6);
        chk(single_phase_o, 1'h0);
        step(10);
        chk(single_phase_o, 1'h0);
        pins_i.slew_busy <= 1'h0;
        step(B / 2);
        chk(single_phase_o, 1'h0);
        step(B);
        chk(single_phase_o, 1'h1);
        pins_i.low_power_state_request <= 1'h1;
        rd(bfpsc_pkg::ADR_STATUS, 32'h30);
        rd(bfpsc_pkg::ADR_CODE, 32'h12);
    endtask

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            final_report;
        end
    end
    initial begin
        rst_i = 1'h1;
        wb_cyc_i = 1'h0;
        wb_stb_i = 1'h0;
        wb_we_i = 1'h0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        voltage_code_i = 8'h0;
        pwm_i = 4'h0;
        // Only the low-power request pin starts high.
        pins_i = 7'h02;
        step(3);
        rst_i <= 1'h0;
        sc_regs;
        sc_therm;
        sc_trip(1'h0);
        sc_trip(1'h1);
        sc_mode;
        sc_code;
        final_report;
    end
endmodule

// file: bfpsc_top.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Droop above limit latches overcurrent fault.
// - Overcurrent fault turns all switches off.
// - Overcurrent must persist 20us before latching.
// - Feedback 150mV above reference latches overvoltage.
// - Overvoltage fault: low side on, high off.
// - Overvoltage must persist 20us before latching.
// - Thermal alert rises below 0.28 rail.
// - Thermal alert falls only above 0.33 rail.
// - Request high: all channels interleaved.
// - Request low: single phase, channel 1 only.
// - Single phase: channel 2 gates high impedance.
// - Single phase: channels 3, 4 at mid-level.
// - Voltage-code change forces interleaved operation.
// - Request ignored during voltage-code transition.
// - Request masked 100us after transition ends.
// - Limit choice follows single or multi phase.
module bfpsc_top #(
    parameter int unsigned BLANK_CYC  = bfpsc_pkg::BLANK_CYCLES,
    parameter int unsigned FILTER_CYC = bfpsc_pkg::FILTER_CYCLES
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    output logic                               irq_o,
    // Analog comparators and pins
    input  wire bfpsc_pkg::bfpsc_pins_t        pins_i,
    input  wire logic [bfpsc_pkg::CODE_W-1:0]  voltage_code_i,
    // PWM requests from the ramp path, bit n is channel n+1
    input  wire logic [bfpsc_pkg::NUM_CH-1:0]  pwm_i,
    // Gate and PWM outputs
    output logic                               ch1_high_gate_o,
    output logic                               ch1_low_gate_o,
    output logic                               ch2_high_gate_o,
    output logic                               ch2_high_gate_oe_o,
    output logic                               ch2_low_gate_o,
    output logic                               ch2_low_gate_oe_o,
    output logic                               ch3_pwm_out_o,
    output logic                               ch3_pwm_mid_o,
    output logic                               ch4_pwm_out_o,
    output logic                               ch4_pwm_mid_o,
    // Status pins
    output logic                               thermal_alert_out_o,
    output logic                               overcurrent_trip_o,
    output logic                               overvoltage_trip_o,
    output logic                               single_phase_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    bfpsc_pkg::bfpsc_pins_t                pins_meta_q;
    bfpsc_pkg::bfpsc_pins_t                pins_q;
    logic [bfpsc_pkg::CODE_W-1:0]          code_meta_q;
    logic [bfpsc_pkg::CODE_W-1:0]          code_q;
    logic [bfpsc_pkg::CODE_W-1:0]          code_last_q;

    always_ff @(posedge clk_i) begin
        // Not reset, so idle pin levels are already through when reset lifts.
        pins_meta_q <= pins_i;
        pins_q      <= pins_meta_q;
        code_meta_q <= voltage_code_i;
        code_q      <= code_meta_q;
        code_last_q <= code_q;
    end

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [bfpsc_pkg::CNT_W-1:0]           oc_cnt_q;
    logic [bfpsc_pkg::CNT_W-1:0]           oc_cnt_d;
    logic [bfpsc_pkg::CNT_W-1:0]           ov_cnt_q;
    logic [bfpsc_pkg::CNT_W-1:0]           ov_cnt_d;
    logic [bfpsc_pkg::CNT_W-1:0]           blank_cnt_q;
    logic [bfpsc_pkg::CNT_W-1:0]           blank_cnt_d;
    logic                                  oc_fault_q;
    logic                                  ov_fault_q;
    logic                                  thermal_q;
    logic                                  thermal_d;
    bfpsc_pkg::bfpsc_mode_t                mode_q;
    bfpsc_pkg::bfpsc_mode_t                mode_d;
    bfpsc_pkg::bfpsc_evt_t                 status_q;
    bfpsc_pkg::bfpsc_evt_t                 status_d;
    bfpsc_pkg::bfpsc_evt_t                 mask_q;
    bfpsc_pkg::bfpsc_evt_t                 events;
    bfpsc_pkg::bfpsc_ctrl_t                ctrl_q;

    // ------------------------------------------------------------
    // Overcurrent and overvoltage filters
    // ------------------------------------------------------------
    localparam logic [bfpsc_pkg::CNT_W-1:0] FILT_LAST = bfpsc_pkg::CNT_W'(FILTER_CYC - 1);
    localparam logic [bfpsc_pkg::CNT_W-1:0] BLANK_LD  = bfpsc_pkg::CNT_W'(BLANK_CYC);
    localparam logic [bfpsc_pkg::CNT_W-1:0] CNT_ONE   = bfpsc_pkg::CNT_W'(1);

    wire single_now   = (mode_q == bfpsc_pkg::MODE_SINGLE);
    // The single-phase limit only applies while one phase carries the load.
    wire oc_cond      = single_now ? pins_q.droop_over_single : pins_q.droop_over_multi;
    wire ov_cond      = pins_q.feedback_over_ref;
    wire oc_hit       = oc_cond && (oc_cnt_q == FILT_LAST);
    wire ov_hit       = ov_cond && (ov_cnt_q == FILT_LAST);

    // A dropout of the condition restarts the persistence count.
    assign oc_cnt_d   = !oc_cond ? '0 : (oc_hit ? oc_cnt_q : oc_cnt_q + CNT_ONE);
    assign ov_cnt_d   = !ov_cond ? '0 : (ov_hit ? ov_cnt_q : ov_cnt_q + CNT_ONE);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oc_cnt_q   <= '0;
            ov_cnt_q   <= '0;
            oc_fault_q <= 1'b0;
            ov_fault_q <= 1'b0;
        end else begin
            oc_cnt_q   <= oc_cnt_d;
            ov_cnt_q   <= ov_cnt_d;
            oc_fault_q <= oc_fault_q | oc_hit;
            ov_fault_q <= ov_fault_q | ov_hit;
        end
    end

    // ------------------------------------------------------------
    // Thermal alert with hysteresis
    // ------------------------------------------------------------
    assign thermal_d = pins_q.thermal_below_set   ? 1'b1 :
                       pins_q.thermal_above_clear ? 1'b0 :
                       thermal_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thermal_q <= 1'b0;
        end else begin
            thermal_q <= thermal_d;
        end
    end

    // ------------------------------------------------------------
    // Phase state
    // ------------------------------------------------------------
    wire code_moved   = (code_q != code_last_q);
    wire transition   = code_moved || pins_q.slew_busy;
    wire lp_allowed   = ctrl_q.low_power_enable && !ctrl_q.force_interleave;
    wire want_single  = lp_allowed && !pins_q.low_power_state_request;

    always_comb begin
        mode_d      = mode_q;
        blank_cnt_d = blank_cnt_q;
        unique case (mode_q)
            bfpsc_pkg::MODE_INTERLEAVE: begin
                if (transition) begin
                    mode_d = bfpsc_pkg::MODE_TRANSITION;
                end else if (want_single) begin
                    mode_d = bfpsc_pkg::MODE_SINGLE;
                end
            end
            bfpsc_pkg::MODE_SINGLE: begin
                if (transition) begin
                    mode_d = bfpsc_pkg::MODE_TRANSITION;
                end else if (!want_single) begin
                    mode_d = bfpsc_pkg::MODE_INTERLEAVE;
                end
            end
            bfpsc_pkg::MODE_TRANSITION: begin
                // The request is not looked at while the code moves.
                if (!transition) begin
                    mode_d      = bfpsc_pkg::MODE_BLANK;
                    blank_cnt_d = BLANK_LD - CNT_ONE;
                end
            end
            bfpsc_pkg::MODE_BLANK: begin
                if (transition) begin
                    mode_d = bfpsc_pkg::MODE_TRANSITION;
                end else if (blank_cnt_q == '0) begin
                    mode_d = bfpsc_pkg::MODE_INTERLEAVE;
                end else begin
                    blank_cnt_d = blank_cnt_q - CNT_ONE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q      <= bfpsc_pkg::MODE_INTERLEAVE;
            blank_cnt_q <= '0;
        end else begin
            mode_q      <= mode_d;
            blank_cnt_q <= blank_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Gate drive per channel
    // ------------------------------------------------------------
    // Channel 0 here is channel 1, which never drops out in single phase.
    logic [bfpsc_pkg::NUM_CH-1:0]          hs_d;
    logic [bfpsc_pkg::NUM_CH-1:0]          ls_d;
    logic [bfpsc_pkg::NUM_CH-1:0]          idle_d;
    logic [bfpsc_pkg::NUM_CH-1:0]          hs_q;
    logic [bfpsc_pkg::NUM_CH-1:0]          ls_q;
    logic [bfpsc_pkg::NUM_CH-1:0]          idle_q;
    logic                                  ch2_oe_q;

    genvar ch;
    generate
        for (ch = 0; ch < bfpsc_pkg::NUM_CH; ch++) begin : g_ch
            // Overcurrent wins over overvoltage: both switches open.
            wire parked = (ch != 0) && single_now;
            assign hs_d[ch]   = !oc_fault_q && !ov_fault_q && !parked && pwm_i[ch];
            assign ls_d[ch]   = !oc_fault_q && (ov_fault_q || (!parked && !pwm_i[ch]));
            assign idle_d[ch] = oc_fault_q || (parked && !ov_fault_q);
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hs_q   <= '0;
            ls_q   <= '0;
            idle_q <= '1;
        end else begin
            hs_q   <= hs_d;
            ls_q   <= ls_d;
            idle_q <= idle_d;
        end
    end

    assign ch1_high_gate_o    = hs_q[0];
    assign ch1_low_gate_o     = ls_q[0];
    assign ch2_high_gate_o    = hs_q[1];
    assign ch2_low_gate_o     = ls_q[1];
    // Channel 2 floats only when parked, not when a fault holds it off.
    assign ch2_high_gate_oe_o = ch2_oe_q;
    assign ch2_low_gate_oe_o  = ch2_oe_q;
    // The mid level shuts the external drivers down; it relies on them honouring it.
    assign ch3_pwm_out_o      = hs_q[2];
    assign ch3_pwm_mid_o      = idle_q[2];
    assign ch4_pwm_out_o      = hs_q[3];
    assign ch4_pwm_mid_o      = idle_q[3];

    logic                                  single_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch2_oe_q    <= 1'b1;
            single_q    <= 1'b0;
        end else begin
            ch2_oe_q    <= !(single_now && !oc_fault_q && !ov_fault_q);
            single_q    <= (mode_d == bfpsc_pkg::MODE_SINGLE);
        end
    end

    assign thermal_alert_out_o = thermal_q;
    assign overcurrent_trip_o  = oc_fault_q;
    assign overvoltage_trip_o  = ov_fault_q;
    assign single_phase_o      = single_q;

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic [31:0]                           rdata_d;
    wire  req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // A write lands at the edge at which the master sees ack.
    wire  wr_en      = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire  hit_status = (wb_adr_i == bfpsc_pkg::ADR_STATUS);
    wire  hit_mask   = (wb_adr_i == bfpsc_pkg::ADR_MASK);
    wire  hit_ctrl   = (wb_adr_i == bfpsc_pkg::ADR_CTRL);
    wire  hit_state  = (wb_adr_i == bfpsc_pkg::ADR_STATE);
    wire  hit_code   = (wb_adr_i == bfpsc_pkg::ADR_CODE);
    wire  rd_status  = req && !wb_we_i && hit_status;

    wire [7:0] state_word = {ctrl_q.low_power_enable, pins_q.low_power_state_request, mode_q,
                             single_now, thermal_q, ov_fault_q, oc_fault_q};

    assign rdata_d = hit_status ? {26'h0, status_q} :
                     hit_mask   ? {26'h0, mask_q} :
                     hit_ctrl   ? {30'h0, ctrl_q} :
                     hit_state  ? {24'h0, state_word} :
                     hit_code   ? {24'h0, code_q} :
                     32'h0;

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign events.overcurrent_trip = oc_hit && !oc_fault_q;
    assign events.overvoltage_trip = ov_hit && !ov_fault_q;
    assign events.thermal_set      = thermal_d && !thermal_q;
    assign events.thermal_clear    = !thermal_d && thermal_q;
    assign events.mode_change      = (mode_d == bfpsc_pkg::MODE_SINGLE) != single_now;
    assign events.code_change      = code_moved;
    // A read clears the bits it returned; a new event in that cycle stays set.
    assign status_d = (rd_status ? '0 : status_q) | events;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            status_q <= '0;
            mask_q   <= bfpsc_pkg::MASK_RST;
            ctrl_q   <= bfpsc_pkg::CTRL_RST;
            irq_o    <= 1'b0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rdata_d : 32'h0;
            status_q <= status_d;
            irq_o    <= |(status_d & mask_q);
            if (wr_en && hit_mask) begin
                mask_q <= wb_dat_i[bfpsc_pkg::EVT_W-1:0];
            end
            if (wr_en && hit_ctrl) begin
                ctrl_q <= wb_dat_i[bfpsc_pkg::CTRL_W-1:0];
            end
        end
    end

endmodule
